//--- logic/uart_break_rx_irda_ctrl.sv
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "uart_defs.svh"
// Function
// [R1] software enables tx, arms break, writes a discarded dummy character
// [R2] software then queues sync character 55h behind the break
// [R3] break is start bit, twelve zero bits, stop bit, on next start
// [R4] hardware clears break request when done; queued sync then sends
// [R5] reading receive data pops fifo; parity/framing flags follow top entry; a read in the cycle a received frame completes does not pop
// [R6] overrun sets on overflow; software 1-to-0 clear empties fifo and shifter
// [R7] infrared enable at mode bit 12 routes pins through codec, 16x only; only tx is encoded, the rx pin is not decoded
// [R8] status bit 14 picks encoded tx idle level when codec enabled
// [R9] mode bit 10 selects alternate pin pair, else primary pair
// [R10] mode bit 15 enables module; clear gives pins back to port latches
// [R11] mode bit 13 halts module in device idle mode
// [R12] wake bit: falling rx edge in sleep interrupts; rising edge clears bit
// [R13] mode bit 6 selects loopback diagnostic mode
// [R14] auto-baud measures next 55h character; hardware clears bit after
// [R15] receive polarity bit: 1 idle low, 0 idle high
// [R16] fast bit gives 4 clocks per bit, else 16
// [R17] format field: 11 9-bit, 10 odd, 01 even, 00 8-bit none
// [R18] stop select bit 0 gives two stop bits when set
// [R19] tx irq mode: 00 load, 01 all done, 10 buffer empty, 11 reserved
// [R20] clearing transmit enable aborts, resets buffer, returns pin to port
// [R21] full flag when tx buffer full; shift-empty when shifter and buffer empty
// [R22] rx irq mode: 11 at 4 chars, 10 at 3 chars, 0x every char
// [R23] address detect, bit 8 marks address, only in 9-bit mode
// [R24] idle flag 1 while receiver idle; data-available while fifo not empty
// [R25] transmit and receive fifos hold four characters each
// [R26] 16-bit divisor sets free-running baud timer period
// [R27] writing divisor clears baud timer immediately
// [R28] loopback feeds transmitter into receiver, ignores external pin
// [R29] frame: low start, data lsb first, optional parity, high stops
module uart_break_rx_irda_ctrl
    import uart_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,

    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,

    // device power state
    input  wire logic        dev_idle_i,
    input  wire logic        dev_sleep_i,

    // serial pins
    input  wire logic        primary_rx_pin_i,
    input  wire logic        alternate_rx_pin_i,
    output logic             primary_tx_pin_o,
    output logic             alternate_tx_pin_o,
    output logic             primary_tx_oe_o,
    output logic             alternate_tx_oe_o,

    // events
    output logic             tx_irq_o,
    output logic             rx_irq_o,
    output logic             wake_irq_o
);

    uart_state_s r, next_r;

    // bit-period ticks per baud clock ratio
    function automatic logic [3:0] ticks_per_bit(input logic fast);
        ticks_per_bit = fast ? 4'h3 : 4'hf; // [R16]
    endfunction

    // number of data bits for a format code
    function automatic logic [3:0] data_bits(input logic [1:0] fmt);
        data_bits = (fmt == 2'b11) ? 4'h9 : 4'h8; // [R17]
    endfunction

    // parity bit value for a character
    function automatic logic parity_of(input logic [1:0] fmt, input logic [7:0] d);
        parity_of = (fmt == 2'b10) ? ~^d : ^d; // [R17]
    endfunction

    // combinational helpers
    logic        wb_req;
    logic        running;
    logic        baud_tick;
    logic        bit_tick;
    logic        rx_raw;
    logic        rx_line;
    logic [1:0]  fmt;
    logic        has_par;
    logic [3:0]  nbits;
    logic [3:0]  frame_len;
    logic [8:0]  txd;
    logic        tx_out;

    logic        rx_push;
    rx_entry_s   rx_new;
    logic        drop;
    logic [15:0] mode_w;
    logic [15:0] sta_w;

    logic [3:0]  half_bit;
    logic [10:0] rx_full;
    logic        ovf;
    logic [1:0]  txim;

    always_comb begin
        next_r   = r;
        wb_req   = cyc_i && stb_i && !r.ack;
        fmt      = r.mode[2:1];
        has_par  = fmt == 2'b01 || fmt == 2'b10;
        nbits    = data_bits(fmt);
        // idle halt and module enable gate the baud timer, transmitter and receiver
        running  = r.mode[`MODE_ON] && !(r.mode[`MODE_IDLE_HALT] && dev_idle_i); // [R10] [R11]
        baud_tick = running && (r.brg_cnt == r.divisor); // [R26]
        bit_tick  = baud_tick && (r.sub_cnt == ticks_per_bit(r.mode[`MODE_FAST]));
        rx_raw   = r.mode[`MODE_LOOP] ? r.tx_line : r.rx_sync[1]; // [R13] [R28]
        rx_line  = r.mode[`MODE_RX_POLARITY_INVERT] ? ~rx_raw : rx_raw; // [R15]
        frame_len = nbits + 4'(has_par) + 4'(r.mode[`MODE_STOP2]) + 4'h1; // [R18]
        txd      = r.txq[r.txq_rd];
        rx_push  = 1'b0;
        rx_new   = '0;
        drop     = 1'b0;
        mode_w   = r.mode;
        sta_w    = r.sta;
        half_bit = ticks_per_bit(r.mode[`MODE_FAST]) >> 1;
        txim     = {r.sta[`STA_TXIM1], r.sta[`STA_TXIM0]};
        ovf      = 1'b0;
        rx_full  = {rx_line, r.rx_sh[10:1]};

        next_r.ack      = wb_req;
        next_r.tx_irq   = 1'b0;
        next_r.rx_irq   = 1'b0;
        next_r.wake_irq = 1'b0;

        // pin synchroniser, primary or alternate pair
        next_r.rx_sync = {r.rx_sync[0],
                          r.mode[`MODE_ALT] ? alternate_rx_pin_i : primary_rx_pin_i}; // [R9] [R7]

        // free-running baud timer
        if (baud_tick) begin
            next_r.brg_cnt = '0;
            next_r.sub_cnt = bit_tick ? 4'h0 : r.sub_cnt + 4'h1;
        end else if (running) begin
            next_r.brg_cnt = r.brg_cnt + 16'h1;
        end

        // transmitter
        if (!r.sta[`STA_TXEN] || !running) begin
            next_r.tx_st   = TX_IDLE; // [R20]
            next_r.txq_cnt = '0;
            next_r.tx_line = 1'b1;
        end else if (r.tx_st == TX_IDLE && r.txq_cnt != 3'h0 && bit_tick) begin
            next_r.txq_rd  = r.txq_rd + 2'h1;
            next_r.txq_cnt = r.txq_cnt - 3'h1;
            next_r.tx_st   = TX_SHIFT;
            next_r.tx_line = 1'b0; // [R29]
            next_r.tx_brk  = r.sta[`STA_BRK];
            if (r.sta[`STA_BRK]) begin
                next_r.tx_sh   = '0; // [R3] dummy character is dropped
                next_r.tx_bits = `BREAK_ZEROS + 4'h1;
            end else if (nbits == 4'h9) begin
                next_r.tx_sh   = {3'b111, txd}; // [R29]
                next_r.tx_bits = frame_len;
            end else begin
                // without parity the parity slot is the first stop bit
                next_r.tx_sh   = {3'b111, has_par ? parity_of(fmt, txd[7:0]) : 1'b1,
                                  txd[7:0]}; // [R29]
                next_r.tx_bits = frame_len;
            end
            next_r.tx_irq = txim == 2'b00 || (txim == 2'b10 && r.txq_cnt == 3'h1); // [R19]
        end else if (r.tx_st == TX_SHIFT && bit_tick) begin
            next_r.tx_line = r.tx_sh[0];
            next_r.tx_sh   = {1'b1, r.tx_sh[11:1]};
            if (r.tx_bits == 4'h0) begin
                next_r.tx_st   = TX_IDLE;
                next_r.tx_line = 1'b1;
                if (r.tx_brk)
                    next_r.sta[`STA_BRK] = 1'b0; // [R4]
                next_r.tx_irq = txim == 2'b01 && r.txq_cnt == 3'h0; // [R19]
            end else begin
                next_r.tx_bits = r.tx_bits - 4'h1;
            end
        end

        // receiver, sampled mid-bit
        if (baud_tick) begin
            case (r.rx_st)
                RX_IDLE: begin
                    if (!rx_line && r.mode[`MODE_AUTO_RATE_MEASURE]) begin
                        next_r.rx_st = RX_BAUD; // [R14]
                        next_r.ab_cnt = '0;
                        next_r.ab_edges = '0;
                    end else if (!rx_line) begin
                        next_r.rx_st   = RX_SHIFT;
                        next_r.rx_sub  = half_bit;
                        next_r.rx_bits = frame_len;
                        next_r.rx_sh   = '0;
                    end
                end

                // first sample taken is the start bit itself
                RX_SHIFT: begin
                    if (r.rx_sub == 4'h0) begin
                        next_r.rx_sub = ticks_per_bit(r.mode[`MODE_FAST]);
                        next_r.rx_sh  = {rx_line, r.rx_sh[10:1]}; // [R29]
                        next_r.rx_bits = r.rx_bits - 4'h1;
                        if (r.rx_bits == 4'h0) begin
                            next_r.rx_st = RX_IDLE;
                            rx_push = 1'b1;
                        end
                    end else begin
                        next_r.rx_sub = r.rx_sub - 4'h1;
                    end
                end

                RX_BAUD: begin
                    // count 16x ticks across the 55h field's falling edges
                    next_r.ab_cnt = r.ab_cnt + 16'h1;
                    if (rx_line == 1'b0 && r.rx_prev) begin
                        next_r.ab_edges = r.ab_edges + 3'h1;
                        if (r.ab_edges == 3'h3) begin
                            next_r.divisor = 16'(r.ab_cnt >> 3) + r.divisor; // [R14]
                            next_r.mode[`MODE_AUTO_RATE_MEASURE] = 1'b0; // [R14]
                            next_r.rx_st = RX_IDLE;
                        end
                    end
                end

                default: next_r.rx_st = RX_IDLE;
            endcase
        end
        next_r.rx_prev = rx_line;

        // frame assembly: last sample is still on the line, align down to data
        rx_new.data = 9'(rx_full >> (4'hb - frame_len));
        // in 8-bit parity mode slot 8 holds the parity bit
        rx_new.parity_fault = has_par && (parity_of(fmt, rx_new.data[7:0]) != rx_new.data[8]); // [R17]
        if (nbits == 4'h8)
            rx_new.data[8] = 1'b0;
        rx_new.framing_fault = !rx_line;
        // address detect drops plain data in 9-bit mode
        if (r.sta[`STA_ADDR_DETECT_ON] && nbits == 4'h9 && !rx_new.data[8])
            drop = 1'b1; // [R23]

        if (rx_push && !drop) begin
            if (r.rxq_cnt == `FIFO_DEPTH) begin
                ovf = 1'b1;
                next_r.sta[`STA_OVERRUN_FAULT] = 1'b1; // [R6]
            end else begin
                next_r.rxq[2'(r.rxq_rd + r.rxq_cnt[1:0])] = rx_new; // [R25]
                next_r.rxq_cnt = r.rxq_cnt + 3'h1;
                next_r.rx_irq = (r.sta[7:6] == 2'b11) ? r.rxq_cnt == 3'h3 :
                                (r.sta[7:6] == 2'b10) ? r.rxq_cnt == 3'h2 : 1'b1; // [R22]
            end
        end

        // wake on start edge while asleep
        if (r.mode[`MODE_WAKE] && dev_sleep_i) begin
            if (!rx_line && r.rx_prev)
                next_r.wake_irq = 1'b1; // [R12]
            if (rx_line && !r.rx_prev)
                next_r.mode[`MODE_WAKE] = 1'b0; // [R12]
        end

        // wishbone register access, one wait state answer
        next_r.rdata = '0;
        if (wb_req && !we_i) begin
            case (adr_i)
                `ADDR_MODE:    next_r.rdata = {16'h0, r.mode};
                `ADDR_STATUS:  next_r.rdata = {16'h0, r.sta};
                `ADDR_RXDATA: begin
                    next_r.rdata = {23'h0, r.rxq[r.rxq_rd].data};
                    if (r.rxq_cnt != 3'h0 && !rx_push) begin
                        next_r.rxq_rd  = r.rxq_rd + 2'h1; // [R5]
                        next_r.rxq_cnt = r.rxq_cnt - 3'h1;
                    end
                end
                `ADDR_DIVISOR: next_r.rdata = {16'h0, r.divisor};
                default:       next_r.rdata = '0;
            endcase
        end else if (wb_req && we_i) begin
            // byte lanes 0 and 1 carry the 16-bit registers
            mode_w = {sel_i[1] ? dat_i[15:8] : r.mode[15:8],
                      sel_i[0] ? dat_i[7:0] : r.mode[7:0]};
            sta_w  = {sel_i[1] ? dat_i[15:8] : r.sta[15:8],
                      sel_i[0] ? dat_i[7:0] : r.sta[7:0]};
            case (adr_i)
                `ADDR_MODE: begin
                    next_r.mode = mode_w & `MODE_WMASK;
                    if (mode_w[`MODE_IR])
                        next_r.mode[`MODE_FAST] = 1'b0; // [R7]
                end

                `ADDR_STATUS: begin
                    // keep hardware updates; break request holds until the break ends
                    next_r.sta = (next_r.sta & ~`STA_WMASK) | (sta_w & `STA_WMASK)
                                 | (next_r.sta & (16'h1 << `STA_BRK));
                    // overrun clears only by software; an overflow in the same cycle wins
                    if (r.sta[`STA_OVERRUN_FAULT] && !sta_w[`STA_OVERRUN_FAULT] && !ovf) begin
                        next_r.sta[`STA_OVERRUN_FAULT] = 1'b0; // [R6]
                        next_r.rxq_cnt = '0; // [R6]
                        next_r.rx_st   = RX_IDLE;
                    end
                end

                `ADDR_TXDATA: begin
                    if (r.txq_cnt != `FIFO_DEPTH && r.sta[`STA_TXEN]) begin
                        next_r.txq[2'(r.txq_rd + r.txq_cnt[1:0])] = dat_i[8:0]; // [R25]
                        next_r.txq_cnt = next_r.txq_cnt + 3'h1;
                    end
                end

                `ADDR_DIVISOR: begin
                    if (sel_i[0]) next_r.divisor[7:0] = dat_i[7:0];
                    if (sel_i[1]) next_r.divisor[15:8] = dat_i[15:8];
                    next_r.brg_cnt = '0; // [R27]
                    next_r.sub_cnt = '0;
                end
                default: ;
            endcase
        end

        // read-only status mirrors
        next_r.sta[`STA_TXFULL] = next_r.txq_cnt == `FIFO_DEPTH; // [R21]
        next_r.sta[`STA_TX_SHIFT_EMPTY]   = next_r.txq_cnt == 3'h0 && next_r.tx_st == TX_IDLE; // [R21]
        next_r.sta[`STA_RECEIVER_QUIET]  = next_r.rx_st == RX_IDLE; // [R24]
        next_r.sta[`STA_RXDA]   = next_r.rxq_cnt != 3'h0; // [R24]
        next_r.sta[`STA_PARITY_FAULT]   = next_r.rxq_cnt != 3'h0 && next_r.rxq[next_r.rxq_rd].parity_fault; // [R5]
        next_r.sta[`STA_FRAMING_FAULT]   = next_r.rxq_cnt != 3'h0 && next_r.rxq[next_r.rxq_rd].framing_fault; // [R5]

        // ir encoder: idle level follows polarity bit, pulse on zero bits
        tx_out = r.tx_line;
        if (r.mode[`MODE_IR])
            tx_out = r.sta[`STA_IRINV] ^ (!r.tx_line && r.sub_cnt < 4'h4); // [R7] [R8]
        next_r.pin_tx = {tx_out, tx_out};
        next_r.pin_oe = (r.mode[`MODE_ON] && r.sta[`STA_TXEN]) ?
                        (r.mode[`MODE_ALT] ? 2'b10 : 2'b01) : 2'b00; // [R9] [R10] [R20]
    end

    // single state register; sync reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
            // idle line and tx pins sit high out of reset
            r.tx_line <= 1'b1;
            r.pin_tx  <= 2'b11;
            r.rx_sync <= 2'b11;
            r.rx_prev <= 1'b1;
            r.sta <= `RESET_WORD | 16'h0110;
        end else begin
            r <= next_r;
        end
    end

    assign dat_o              = r.rdata;
    assign ack_o              = r.ack;

    assign primary_tx_pin_o   = r.pin_tx[0];
    assign alternate_tx_pin_o = r.pin_tx[1];
    assign primary_tx_oe_o    = r.pin_oe[0];
    assign alternate_tx_oe_o  = r.pin_oe[1];

    assign tx_irq_o           = r.tx_irq;
    assign rx_irq_o           = r.rx_irq;
    assign wake_irq_o         = r.wake_irq;

endmodule // uart_break_rx_irda_ctrl

//--- logic/uart_defs.svh
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH

// register byte addresses on the wishbone bus
`define ADDR_MODE      5'h00
`define ADDR_STATUS    5'h04
`define ADDR_TXDATA    5'h08
`define ADDR_RXDATA    5'h0c
`define ADDR_DIVISOR   5'h10

// mode register fields
`define MODE_ON        15
`define MODE_IDLE_HALT 13
`define MODE_IR        12
`define MODE_ALT       10
`define MODE_WAKE      7
`define MODE_LOOP      6
`define MODE_AUTO_RATE_MEASURE     5
`define MODE_RX_POLARITY_INVERT     4
`define MODE_FAST      3
`define MODE_STOP2     0
`define MODE_WMASK     16'hb4ff

// status register fields
`define STA_TXIM1      15
`define STA_IRINV      14
`define STA_TXIM0      13
`define STA_BRK        11
`define STA_TXEN       10
`define STA_TXFULL     9
`define STA_TX_SHIFT_EMPTY       8
`define STA_ADDR_DETECT_ON      5
`define STA_RECEIVER_QUIET      4
`define STA_PARITY_FAULT       3
`define STA_FRAMING_FAULT       2
`define STA_OVERRUN_FAULT       1
`define STA_RXDA       0
`define STA_WMASK      16'hece0

`define RESET_WORD     16'h0000
`define SYNC_CHAR      9'h055
`define BREAK_ZEROS    4'hc
`define FIFO_DEPTH     3'h4

`endif

//--- logic/uart_pkg.sv
package uart_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_e;
    typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_BAUD} rx_state_e;

    // one receive fifo entry: data plus its own error flags
    typedef struct packed {
        logic       parity_fault;
        logic       framing_fault;
        logic [8:0] data;
    } rx_entry_s;

    typedef struct packed {
        logic [15:0]      mode;
        logic [15:0]      sta;
        logic [15:0]      divisor;
        logic [15:0]      brg_cnt;
        logic [3:0]       sub_cnt;
        logic [3:0][8:0]  txq;
        logic [2:0]       txq_cnt;
        logic [1:0]       txq_rd;
        tx_state_e        tx_st;
        logic [11:0]      tx_sh;
        logic [3:0]       tx_bits;
        logic             tx_brk;
        logic             tx_line;
        rx_entry_s [3:0]  rxq;
        logic [2:0]       rxq_cnt;
        logic [1:0]       rxq_rd;
        rx_state_e        rx_st;
        logic [3:0]       rx_sub;
        logic [3:0]       rx_bits;
        logic [10:0]      rx_sh;
        logic [15:0]      ab_cnt;
        logic [2:0]       ab_edges;
        logic [1:0]       rx_sync;
        logic             rx_prev;
        logic [31:0]      rdata;
        logic             ack;
        logic             tx_irq;
        logic             rx_irq;
        logic             wake_irq;
        logic [1:0]       pin_tx;
        logic [1:0]       pin_oe;
    } uart_state_s;
endpackage

//--- tb/uart_ctrl_properties.sv
`timescale 1ns/1ps
module uart_ctrl_properties (
    // clock, reset, bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [4:0]  adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // pins and events
    input wire logic        dev_sleep_i,
    input wire logic        primary_tx_pin_o,
    input wire logic        alternate_tx_pin_o,
    input wire logic        primary_tx_oe_o,
    input wire logic        alternate_tx_oe_o,
    input wire logic        wake_irq_o
);
    logic       on_m;
    logic       alt_m;
    logic       txen_m;
    logic [3:0] age;
    logic [3:0] slp;
    wire        wr_ok = cyc_i && stb_i && we_i && ack_o;
    // shadow of the routing bits; age lets the registered pins settle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            on_m <= 1'b0;
            alt_m <= 1'b0;
            txen_m <= 1'b0;
            age <= 4'h0;
            slp <= 4'hf;
        end else begin
            if (wr_ok && adr_i == 5'h00) begin
                on_m <= dat_i[15];
                alt_m <= dat_i[10];
            end
            if (wr_ok && adr_i == 5'h04) begin
                txen_m <= dat_i[10];
            end
            age <= wr_ok ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
            slp <= dev_sleep_i ? 4'h0 : (slp == 4'hf ? slp : slp + 4'h1);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_answer;
        ack_o ##1 !ack_o;
    endsequence
    a_ack_after_take: assert property (s_take |=> s_answer)
        else $error("bus request not answered in one cycle");
    a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !primary_tx_oe_o
        && !alternate_tx_oe_o && primary_tx_pin_o && alternate_tx_pin_o)
        else $error("outputs not quiet after reset");
    a_upper_half_zero: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_unmapped_zero: assert property (ack_o && !we_i && adr_i > 5'h10 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_off_releases_pins: assert property (age == 4'h8 && !on_m |->
        !primary_tx_oe_o && !alternate_tx_oe_o) else $error("pins driven while off");
    a_primary_route: assert property (age == 4'h8 && on_m && !alt_m |->
        primary_tx_oe_o == txen_m && !alternate_tx_oe_o) else $error("primary route wrong");
    a_alt_route: assert property (age == 4'h8 && on_m && alt_m |->
        alternate_tx_oe_o == txen_m && !primary_tx_oe_o) else $error("alternate route wrong");
    a_wake_needs_sleep: assert property (wake_irq_o |-> slp < 4'h6)
        else $error("wake event outside sleep");
endmodule // uart_ctrl_properties

//--- tb/remote_uart_model.sv
`timescale 1ns/1ps
module remote_uart_model (
    // clock
    input  wire logic clk_i,
    // serial lines
    input  wire logic line_i,
    output logic      line_o
);
    int         bit_clks = 32;
    int         max_low = 0;
    time        low_t0 = 0;
    logic [8:0] got_q[$];
    initial line_o = 1'b1;
    // longest low run, sizes a break
    always @(negedge line_i) low_t0 = $time;
    always @(posedge line_i) begin
        if (int'($time - low_t0) > max_low) max_low = int'($time - low_t0);
    end
    // mid-bit sampling of nine slots after the start bit
    initial forever begin : rx_proc
        logic [8:0] d;
        @(negedge line_i);
        repeat (bit_clks / 2) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (bit_clks) @(posedge clk_i);
            d[i] = line_i;
        end
        got_q.push_back(d);
    end
    // low start, data lsb first, high stop
    task automatic send_char(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_o <= f[i];
            repeat (bit_clks) @(posedge clk_i);
        end
    endtask
endmodule // remote_uart_model

//--- tb/uart_break_rx_irda_ctrl_test.sv
`timescale 1ns/1ps
`include "uart_defs.svh"
module uart_break_rx_irda_ctrl_test;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [4:0]  adr_i = 5'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic        dev_idle_i = 1'b0;
    logic        dev_sleep_i = 1'b0;
    logic        alt_rx = 1'b1;
    wire  [31:0] dat_o;
    wire         ack_o, tx_irq_o, rx_irq_o, wake_irq_o, rx_line;
    wire         primary_tx_pin_o, alternate_tx_pin_o, primary_tx_oe_o, alternate_tx_oe_o;
    // released pin floats high through its pull-up
    wire         tx_line = primary_tx_oe_o ? primary_tx_pin_o : 1'b1;
    int          fail_count = 0;
    int          n_checks = 0;
    int          rx_irqs = 0;
    int          wake_irqs = 0;
    logic [31:0] q;
    always #2 clk_i = ~clk_i;
    // one-cycle pulses, counted at every rising edge
    always @(posedge clk_i) begin
        if (rx_irq_o === 1'b1) rx_irqs++;
        if (wake_irq_o === 1'b1) wake_irqs++;
    end
    uart_break_rx_irda_ctrl dut_u (.primary_rx_pin_i(rx_line), .alternate_rx_pin_i(alt_rx), .*);
    remote_uart_model peer_u (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line));
    task automatic check(input logic [31:0] seen, input logic [31:0] ex, input string what);
        n_checks++;
        if (seen !== ex) begin
            fail_count++;
            $display("ERROR %0t %s seen %h expected %h", $time, what, seen, ex);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic [4:0] a, input logic w, input logic [15:0] d,
                      output logic [31:0] q);
        int n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h3;
        dat_i <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 64);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        check(n < 64, 1'b1, "no ack");
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        wb(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        wb(a, 1'b0, 16'h0000, q);
    endtask
    task automatic wait_chars(input int n);
        int k = 0;
        while (peer_u.got_q.size() < n && k < 20000) begin
            @(posedge clk_i);
            k++;
        end
        check(k < 20000, 1'b1, "char wait");
    endtask
    task automatic t_regs;
        rd(`ADDR_STATUS, q);
        check(q, 32'h0000_0110, "status reset");
        rd(`ADDR_MODE, q);
        check(q, 32'h0, "mode reset");
        wr(5'h14, 16'hffff);
        rd(5'h14, q);
        check(q, 32'h0, "unmapped");
        wr(`ADDR_DIVISOR, 16'h0001);
        wr(`ADDR_MODE, 16'h8400);
        wr(`ADDR_STATUS, 16'h0400);
        idle(10);
        check(alternate_tx_oe_o, 1'b1, "alt oe");
        check(primary_tx_oe_o, 1'b0, "primary oe");
        wr(`ADDR_MODE, 16'h8000);
        idle(10);
        check(primary_tx_oe_o, 1'b1, "primary oe");
    endtask
    // every format code; slot nine is stop, parity or data bit 8
    task automatic t_formats;
        logic [8:0] ex [4];
        ex = '{9'h1a5, 9'h0a5, 9'h1a5, 9'h1a5};
        for (int f = 0; f < 4; f++) begin
            wr(`ADDR_MODE, 16'h8000 | 16'(f << 1));
            wr(`ADDR_TXDATA, 16'h01a5);
            wait_chars(1);
            check(peer_u.got_q.pop_front(), ex[f], "tx frame");
            idle(64);
        end
        wr(`ADDR_MODE, 16'h8000);
    endtask
    task automatic t_break;
        peer_u.max_low = 0;
        peer_u.got_q.delete();
        wr(`ADDR_STATUS, 16'h0c00);
        wr(`ADDR_TXDATA, 16'h00ff);
        wr(`ADDR_TXDATA, 16'h0055);
        wait_chars(2);
        check(peer_u.got_q.pop_front(), 32'h0, "break bits");
        check(peer_u.got_q.pop_front(), 32'h155, "sync char");
        check((peer_u.max_low + 64) / 128, 13, "break span");
        idle(64);
        rd(`ADDR_STATUS, q);
        check(q[11], 1'b0, "break clear");
        check(q[8], 1'b1, "shift empty");
    endtask
    task automatic t_rx;
        rx_irqs = 0;
        for (int i = 0; i < 4; i++) peer_u.send_char(8'h30 + 8'(i));
        idle(64);
        check(rx_irqs, 4, "rx events");
        rd(`ADDR_STATUS, q);
        check(q[4:0], 5'h11, "rx status");
        peer_u.send_char(8'h40);
        idle(64);
        rd(`ADDR_STATUS, q);
        check(q[1], 1'b1, "overrun");
        rd(`ADDR_RXDATA, q);
        check(q[8:0], 9'h030, "rx top");
        rd(`ADDR_RXDATA, q);
        check(q[8:0], 9'h031, "rx next");
        wr(`ADDR_STATUS, 16'h0400);
        rd(`ADDR_STATUS, q);
        check(q[1:0], 2'b00, "overrun clear");
    endtask
    // 4x frame is 80 cycles, a 16x one would not fit in 200
    task automatic t_loop;
        wr(`ADDR_MODE, 16'h8048);
        wr(`ADDR_TXDATA, 16'h003c);
        idle(200);
        rd(`ADDR_RXDATA, q);
        check(q[8:0], 9'h03c, "loopback");
        wr(`ADDR_MODE, 16'h8000);
    endtask
    task automatic t_wake;
        wake_irqs = 0;
        dev_sleep_i <= 1'b1;
        wr(`ADDR_MODE, 16'h8080);
        peer_u.send_char(8'hf0);
        idle(8);
        dev_sleep_i <= 1'b0;
        check(wake_irqs, 1, "wake event");
        rd(`ADDR_MODE, q);
        check(q[7], 1'b0, "wake clear");
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_formats;
        t_break;
        t_rx;
        t_loop;
        t_wake;
        print_verdict;
    end
    // run needs far less
    initial begin
        #400000;
        fail_count++;
        $display("ERROR %0t watchdog expired", $time);
        print_verdict;
    end
endmodule // uart_break_rx_irda_ctrl_test
bind uart_break_rx_irda_ctrl uart_ctrl_properties props_u (.*);
